/* File: verification/line_side_model.sv */
// Far-end line model: paces line bits and counts them
`timescale 1ns/1ps
module line_side_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow,
	output logic     bit_tick,
	output logic     cts_on,
	output integer   tick_count
);
	logic [3:0] div_ff;
	// Clear to send held on so patterns may start at once
	assign cts_on = 1'b1;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_ff <= 4'h0;
			bit_tick <= 1'b0;
			tick_count <= 0;
		end else begin
			div_ff <= div_ff + 4'h1;
			bit_tick <= slow ? (div_ff == 4'hF) : (div_ff[1:0] == 2'h3);
			tick_count <= tick_count + (bit_tick ? 1 : 0);
		end
	end
endmodule // line_side_model

/* File: verification/test_voice_loop_ctrl.sv */
// Self-checking bench for the voice and loopback control bank
`timescale 1ns/1ps
module test_voice_loop_ctrl;
	logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
	logic        data_mode = 1'b0, unscr_ones_raw = 1'b0, ack_pattern_raw = 1'b0, serial_tx_data = 1'b0;
	logic        rts_on = 1'b1, dtr_on = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, v;
	logic [15:0] rx_voice_sample = 16'h0000, dac_sample, s;
	logic        irq, bit_tick, cts_on, dac_strobe, agc_active, voice_running, tx_output_squelch, tx_line_bit;
	logic        tx_line_valid, tx_data_clock_pin, rx_data_clock_pin, carrier_on, fsk1200_half_duplex;
	integer      tick_count, num_errors = 0, comparisons = 0, seed = 32'hd22bdce7, n, i;
	logic [15:0] q[$];
	logic        scr_on = 1'b0;
	logic [6:0]  hist = 7'h00;
	logic [7:0]  codes[5] = '{8'hAC, 8'h80, 8'h81, 8'h83, 8'h86};
	logic [4:0]  regs[10] = '{5'h02, 5'h04, 5'h05, 5'h08, 5'h0D, 5'h0F, 5'h11, 5'h13, 5'h1E, 5'h1F};
	always #2 mclk = ~mclk;
	line_side_model far (.*);
	voice_loop_ctrl #(.VOICE_DIV(8)) dut (.*);
	//////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input integer k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	// A zero mask only fetches the byte for polling
	task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		if (m != 8'h00) chk(v & m, e);
		@(posedge mclk);
	endtask
	task automatic strobe;
		@(posedge mclk);
		for (n = 0; n < 100 && dac_strobe !== 1'b1; n++) @(posedge mclk);
	endtask
	// Line bits obey the self-synchronising recurrence of the pattern while it is sent
	always @(posedge mclk) begin
		if (tx_line_valid === 1'b1) begin
			if (scr_on) chk(tx_line_bit, 1'b1 ^ hist[3] ^ hist[6]);
			hist <= {hist[5:0], tx_line_bit};
		end
	end
	task automatic conclude;
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (regs[j]) rd(regs[j], 8'hFF, 8'h00);
		wr(5'h1A, 8'hFF);
		rd(5'h1A, 8'hFF, 8'h00);
		wr(5'h05, 8'h10);
		cyc(2);
		chk(tx_output_squelch, 1);
		rd(5'h05, 8'h10, 8'h10);
		wr(5'h05, 8'h00);
		cyc(2);
		chk(tx_output_squelch, 0);
		wr(5'h13, 8'h80);
		wr(5'h1F, 8'h02);
		wr(5'h04, 8'h24);
		wr(5'h05, 8'h20);
		rd(5'h05, 8'h20, 8'h20);
		for (n = 0; n < 400 && voice_running !== 1'b1; n++) @(posedge mclk);
		cyc(3);
		rd(5'h05, 8'h20, 8'h00);
		chk(irq, 1);
		rd(5'h1E, 8'h02, 8'h02);
		chk(irq, 0);
		chk(agc_active, 1);
		wr(5'h04, 8'h20);
		cyc(2);
		chk(agc_active, 0);
		for (i = 0; i < 5; i++) begin
			s = $random(seed);
			q.push_back(s);
			wr(5'h13, codes[i]);
			wr(5'h11, {i[0], 7'h10});
			// With the buffer on both bytes go to one place, low first
			wr(i[0] ? 5'h10 : 5'h12, s[7:0]);
			wr(5'h10, s[15:8]);
			strobe();
			chk(dac_sample, q.pop_front());
		end
		// Decoder on, buffer off: the low nibble of the secondary byte is the step code
		wr(5'h11, 8'h50);
		wr(5'h12, 8'h05);
		wr(5'h10, 8'h00);
		strobe();
		chk(dac_sample, s + 16'h0050);
		wr(5'h12, 8'h0B);
		wr(5'h10, 8'h00);
		strobe();
		chk(dac_sample, s + 16'h0020);
		i = tick_count;
		wr(5'h08, 8'h08);
		rd(5'h08, 8'h08, 8'h08);
		scr_on = 1'b1;
		for (v = 8'h08; v[3] && tick_count - i < 3000; ) rd(5'h08, 8'h00, 8'h00);
		scr_on = 1'b0;
		chk(tick_count - i >= 1947 && tick_count - i <= 1951, 1);
		chk(irq, 0);
		rd(5'h1E, 8'h01, 8'h01);
		unscr_ones_raw <= 1'b1;
		cyc(4);
		rd(5'h0D, 8'h08, 8'h00);
		data_mode <= 1'b1;
		cyc(4);
		rd(5'h0D, 8'h08, 8'h08);
		unscr_ones_raw <= 1'b0;
		cyc(4);
		rd(5'h0D, 8'h08, 8'h00);
		wr(5'h02, 8'h02);
		ack_pattern_raw <= 1'b1;
		cyc(4);
		rd(5'h0F, 8'h01, 8'h01);
		ack_pattern_raw <= 1'b0;
		cyc(4);
		wr(5'h0F, 8'h00);
		rd(5'h0F, 8'h01, 8'h00);
		wr(5'h11, 8'h04);
		wr(5'h13, 8'hA4);
		chk(fsk1200_half_duplex, 1);
		chk(carrier_on, 1);
		rts_on <= 1'b0;
		cyc(4);
		chk(carrier_on, 0);
		rts_on <= 1'b1;
		cyc(4);
		chk(carrier_on, 1);
		wr(5'h13, 8'hA0);
		chk(fsk1200_half_duplex, 0);
		ack_pattern_raw <= 1'b1;
		cyc(4);
		rd(5'h0F, 8'h01, 8'h00);
		ack_pattern_raw <= 1'b0;
		cyc(4);
		slow <= 1'b1;
		wr(5'h08, 8'h20);
		wr(5'h13, 8'hA0);
		n = 0;
		i = 0;
		repeat (64) begin
			@(posedge mclk);
			n += tx_data_clock_pin;
			i += rx_data_clock_pin;
		end
		chk(n, 4);
		chk(i, 60);
		conclude();
	end
endmodule // test_voice_loop_ctrl

/* File: verification/voice_loop_monitor.sv */
// Port checker for the voice and loopback control bank
`timescale 1ns/1ps
module voice_loop_monitor #(parameter INIT_CYC = 250) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       bit_tick,
	input wire logic       tx_line_valid,
	input wire logic       tx_data_clock_pin,
	input wire logic       rx_data_clock_pin,
	input wire logic       dac_strobe,
	input wire logic       tx_output_squelch,
	input wire logic       agc_active,
	input wire logic       voice_running
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A quiet cycle after the write lets a one or two cycle output path settle
	sequence s_sq;
		reg_wr && reg_addr == 5'h05 ##1 !(reg_wr && reg_addr == 5'h05);
	endsequence
	sequence s_agc_off;
		reg_wr && reg_addr == 5'h04 && !reg_wdata[2] ##1 !(reg_wr && reg_addr == 5'h04);
	endsequence
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	AST_SQUELCH: assert property (s_sq |=> tx_output_squelch == $past(reg_wdata[4], 2))
		else $error("squelch does not follow its bit");
	AST_AGC_OFF: assert property (s_agc_off |=> !agc_active)
		else $error("gain control still on");
	AST_VOICE_UP: assert property (reg_wr && reg_addr == 5'h05 && reg_wdata[5] |-> ##[1:300] voice_running)
		else $error("voice did not start");
	AST_TX_VALID: assert property (tx_line_valid |-> $past(bit_tick))
		else $error("line bit off the bit rate");
	AST_CLK_EXCL: assert property (!(tx_data_clock_pin && rx_data_clock_pin))
		else $error("both data clocks high");
	AST_SYNC_CLK: assert property (tx_data_clock_pin |-> $past(bit_tick))
		else $error("transmit clock off the bit rate");
	AST_DAC_PULSE: assert property (dac_strobe |=> !dac_strobe)
		else $error("converter strobe too long");
endmodule // voice_loop_monitor
bind voice_loop_ctrl voice_loop_monitor #(.INIT_CYC(INIT_CYC)) u_mon (.*);

/* File: verilog/voice_loop_ctrl.v */
// Voice, squelch, FSK mode and loopback acknowledgment control bits of the data pump
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "voice_loop_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Squelch bit silences analog output only
// - Decoder enable bit picks ADPCM or pass-through
// - ADPCM mode decodes host voice bytes
// - Pass-through forwards samples straight to DAC
// - Samples at rate; FIFO selects byte source
// - Unscrambled-ones flag follows detector, gated by data
// - Voice AGC runs only when bit set
// - Voice initiate starts voice, then self-clears
// - Sync bit selects sync in FSK300 config
// - Sync mode drives clocks, parallel or serial
// - Half duplex FSK1200 needs A4h, RTS, DTR
// - Ack bit with CTS sends 1948 scrambled ones
// - Ack bit clears after full pattern sent
// - Loop detection both modes, never FSK
// - Ack detector enable drives shared detected flag
////////////////////////////////////////////////////////////////////////////////
module voice_loop_ctrl #(
	parameter VOICE_DIV    = `VOICE_DIV,
	parameter ACK_BITS     = `ACK_PATTERN_BITS,
	parameter INIT_CYC     = `VOICE_INIT_CYC
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire [4:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	output wire        irq,
	input  wire        data_mode,
	input  wire        cts_on,
	input  wire        rts_on,
	input  wire        dtr_on,
	input  wire        bit_tick,
	input  wire        unscr_ones_raw,
	input  wire        ack_pattern_raw,
	input  wire        serial_tx_data,
	// Reserved for the receive voice path; nothing reads it yet
	input  wire [15:0] rx_voice_sample,
	output reg  [15:0] dac_sample,
	output reg         dac_strobe,
	output reg         agc_active,
	output reg         voice_running,
	output reg         tx_output_squelch,
	output reg         tx_line_bit,
	output reg         tx_line_valid,
	output reg         tx_data_clock_pin,
	output reg         rx_data_clock_pin,
	output reg         carrier_on,
	output wire        fsk1200_half_duplex
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions

// Configuration families decide which control bits take effect
function is_voice_configuration_code;
	input [7:0] c;
	begin
		is_voice_configuration_code = (c == `CONFIGURATION_CODE_DTMF_A) || (c == `CONFIGURATION_CODE_TONE_0) || (c == `CONFIGURATION_CODE_TONE_1) ||
			(c == `CONFIGURATION_CODE_TONE_3) || (c == `CONFIGURATION_CODE_TONE_6);
	end
endfunction

function is_fsk_configuration_code;
	input [7:0] c;
	begin
		is_fsk_configuration_code = (c == `CONFIGURATION_CODE_FSK300) || (c == `CONFIGURATION_CODE_FSK300_CH2) || (c == `CONFIGURATION_CODE_FSK1200);
	end
endfunction

// Sign-magnitude 4-bit code to linear step; a compact stand-in for the full adaptive decoder
function [15:0] adpcm_step;
	input [15:0] prev;
	input [3:0]  code;
	reg   [15:0] delta;
	begin
		delta      = {9'h000, code[2:0], 4'h0};
		adpcm_step = code[3] ? (prev - delta) : (prev + delta);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [1:0] sync_data_ff;
reg [1:0] sync_cts_ff;
reg [1:0] sync_rts_ff;
reg [1:0] sync_dtr_ff;
reg [1:0] sync_u1_ff;
reg [1:0] sync_ack_ff;
reg [1:0] sync_txd_ff;

// Every pin level crosses in through two flops and only the second stage is read;
// two cycles of latency are the price of a clean crossing

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		sync_data_ff <= 2'h0;
		sync_cts_ff  <= 2'h0;
		sync_rts_ff  <= 2'h0;
		sync_dtr_ff  <= 2'h0;
		sync_u1_ff   <= 2'h0;
		sync_ack_ff  <= 2'h0;
		sync_txd_ff  <= 2'h0;
	end else begin
		sync_data_ff <= {sync_data_ff[0], data_mode};
		sync_cts_ff  <= {sync_cts_ff[0], cts_on};
		sync_rts_ff  <= {sync_rts_ff[0], rts_on};
		sync_dtr_ff  <= {sync_dtr_ff[0], dtr_on};
		sync_u1_ff   <= {sync_u1_ff[0], unscr_ones_raw};
		sync_ack_ff  <= {sync_ack_ff[0], ack_pattern_raw};
		sync_txd_ff  <= {sync_txd_ff[0], serial_tx_data};
	end
end

wire data_s = sync_data_ff[1];
wire cts_s  = sync_cts_ff[1];
wire rts_s  = sync_rts_ff[1];
wire dtr_s  = sync_dtr_ff[1];
wire u1_s   = sync_u1_ff[1];
wire ack_s  = sync_ack_ff[1];
wire txd_s  = sync_txd_ff[1];

////////////////////////////////////////////////////////////////////////////////
// Control registers

reg  [7:0]  det_enable_ff;
reg  [7:0]  voice_rx_ff;
reg  [7:0]  voice_ctl_ff;
reg  [7:0]  tx_mode_ff;
reg  [7:0]  voice_tx_ff;
reg  [7:0]  config_ff;
reg  [7:0]  vbuf_ff;
reg  [7:0]  secbuf_ff;
reg  [15:0] fifo_sample_ff;
reg         byte_phase_ff;
reg         sample_ready_ff;
reg         pat_det_ff;
reg         unscr_ff;
reg  [3:0]  irq_stat_ff;
reg  [3:0]  irq_mask_ff;
reg         ack_done_ev;
reg         init_done_ev;

// Write hits; unmapped addresses match none and so are ignored
wire wr_hit_det   = reg_wr && (reg_addr == `OFS_DET_ENABLE);
wire wr_hit_vctl  = reg_wr && (reg_addr == `OFS_VOICE_CTL);
wire wr_hit_txm   = reg_wr && (reg_addr == `OFS_TX_MODE);
wire wr_hit_vbuf  = reg_wr && (reg_addr == `OFS_VOICE_TX_BUF);
wire wr_hit_pstat = reg_wr && (reg_addr == `OFS_PATTERN_STAT);

wire fifo_en     = voice_tx_ff[`BIT_FIFO_EN];
wire tx_voice_on = voice_tx_ff[`BIT_TX_VOICE] && is_voice_configuration_code(config_ff);
wire fsk_mode    = is_fsk_configuration_code(config_ff);
// Pattern detection is held off in FSK configurations
wire pat_event   = det_enable_ff[`BIT_ACK_DET_EN] && ack_s && !fsk_mode;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		det_enable_ff   <= `RST_BYTE;
		voice_rx_ff     <= `RST_BYTE;
		voice_ctl_ff    <= `RST_BYTE;
		tx_mode_ff      <= `RST_BYTE;
		voice_tx_ff     <= `RST_BYTE;
		config_ff       <= `RST_BYTE;
		vbuf_ff         <= `RST_BYTE;
		secbuf_ff       <= `RST_BYTE;
		fifo_sample_ff  <= 16'h0000;
		byte_phase_ff   <= 1'b0;
		sample_ready_ff <= 1'b0;
		pat_det_ff      <= 1'b0;
	end else begin
		if (wr_hit_det)
			det_enable_ff <= reg_wdata;
		if (reg_wr && (reg_addr == `OFS_VOICE_RX))
			voice_rx_ff <= reg_wdata;
		if (reg_wr && (reg_addr == `OFS_VOICE_TX))
			voice_tx_ff <= reg_wdata;
		if (reg_wr && (reg_addr == `OFS_CONFIG))
			config_ff <= reg_wdata;
		if (reg_wr && (reg_addr == `OFS_SEC_TX_BUF))
			secbuf_ff <= reg_wdata;
		// A host write that meets a hardware clear keeps the written value, so a
		// fresh request is never lost
		// Voice initiate: write sets, hardware clears when initiation ends; a new set wins
		if (wr_hit_vctl)
			voice_ctl_ff <= reg_wdata;
		else if (init_done_ev)
			voice_ctl_ff[`BIT_VOICE_INIT] <= 1'b0;
		if (wr_hit_txm)
			tx_mode_ff <= reg_wdata;
		else if (ack_done_ev)
			tx_mode_ff[`BIT_ACK_SEND] <= 1'b0;
		// Voice buffer: FIFO mode pairs low then high byte, else high byte with secondary low
		if (wr_hit_vbuf) begin
			vbuf_ff <= reg_wdata;
			if (fifo_en) begin
				byte_phase_ff <= ~byte_phase_ff;
				if (byte_phase_ff) begin
					fifo_sample_ff  <= {reg_wdata, vbuf_ff};
					sample_ready_ff <= 1'b1;
				end
			end else begin
				fifo_sample_ff  <= {reg_wdata, secbuf_ff};
				sample_ready_ff <= 1'b1;
				byte_phase_ff   <= 1'b0;
			end
		end else if (dac_strobe) begin
			sample_ready_ff <= 1'b0;
		end
		// Detected flag: host write of zero clears it, a new detection wins
		if (pat_event)
			pat_det_ff <= 1'b1;
		else if (wr_hit_pstat && !reg_wdata[`BIT_PAT_DET])
			pat_det_ff <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Voice path

reg [31:0] rate_cnt_ff;
reg [31:0] init_cnt_ff;
// Free-running rate divider: a sample waits for the next tick, so the host may
// write at any point of the period; a short VOICE_DIV only speeds up simulation
wire       rate_tick = (rate_cnt_ff == VOICE_DIV - 1);

// Initiation is a fixed wait of INIT_CYC cycles after the bit is set

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		rate_cnt_ff   <= 32'h00000000;
		init_cnt_ff   <= 32'h00000000;
		init_done_ev  <= 1'b0;
		voice_running <= 1'b0;
		dac_sample    <= 16'h0000;
		dac_strobe    <= 1'b0;
		agc_active    <= 1'b0;
	end else begin
		rate_cnt_ff  <= rate_tick ? 32'h00000000 : rate_cnt_ff + 32'h00000001;
		init_done_ev <= 1'b0;
		dac_strobe   <= 1'b0;
		if (voice_ctl_ff[`BIT_VOICE_INIT] && !wr_hit_vctl && !init_done_ev) begin
			if (init_cnt_ff == INIT_CYC - 1) begin
				init_cnt_ff   <= 32'h00000000;
				init_done_ev  <= 1'b1;
				voice_running <= 1'b1;
			end else begin
				init_cnt_ff <= init_cnt_ff + 32'h00000001;
			end
		end
		if (rate_tick && sample_ready_ff && tx_voice_on && voice_running) begin
			dac_strobe <= 1'b1;
			// Decoder or pass-through is chosen per sample, so a mode change needs no flush
			if (voice_tx_ff[`BIT_DEC_EN])
				dac_sample <= adpcm_step(dac_sample, fifo_sample_ff[3:0]);
			else
				dac_sample <= fifo_sample_ff;
		end
		agc_active <= voice_rx_ff[`BIT_RX_VOICE] && voice_rx_ff[`BIT_VOICE_AGC] && voice_running;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Transmit line, acknowledgment pattern, FSK modes

reg [6:0]  scr_ff;
reg [11:0] ack_cnt_ff;
// The scrambler feeds on its own output alone and needs no seed from the host.
// The bit counter restarts whenever the pattern is not being sent, so losing
// CTS in mid-pattern sends the full count again once CTS returns
wire       scr_out  = 1'b1 ^ scr_ff[3] ^ scr_ff[6];
wire       ack_busy = tx_mode_ff[`BIT_ACK_SEND] && cts_s && !fsk_mode;
wire       sync_fsk = (config_ff == `CONFIGURATION_CODE_FSK300) && tx_mode_ff[`BIT_SYNC_SEL];

// Half duplex needs both the bit and the FSK1200 code
assign fsk1200_half_duplex = voice_tx_ff[`BIT_HALF_DUPLEX] && (config_ff == `CONFIGURATION_CODE_FSK1200);

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		scr_ff            <= 7'h00;
		ack_cnt_ff        <= 12'h000;
		ack_done_ev       <= 1'b0;
		tx_line_bit       <= 1'b1;
		tx_line_valid     <= 1'b0;
		tx_output_squelch <= 1'b0;
		tx_data_clock_pin <= 1'b0;
		rx_data_clock_pin <= 1'b0;
		carrier_on        <= 1'b0;
		unscr_ff          <= 1'b0;
	end else begin
		ack_done_ev   <= 1'b0;
		tx_line_valid <= bit_tick;
		// The done pulse blocks one more step so the count cannot wrap into a second pattern
		if (ack_busy && !ack_done_ev) begin
			if (bit_tick) begin
				scr_ff      <= {scr_ff[5:0], scr_out};
				tx_line_bit <= scr_out;
				if (ack_cnt_ff == ACK_BITS - 1) begin
					ack_cnt_ff  <= 12'h000;
					ack_done_ev <= 1'b1;
				end else begin
					ack_cnt_ff <= ack_cnt_ff + 12'h001;
				end
			end
		end else begin
			ack_cnt_ff <= 12'h000;
			if (bit_tick)
				tx_line_bit <= tx_mode_ff[`BIT_PAR_MODE] ? vbuf_ff[0] : txd_s;
		end
		tx_output_squelch <= voice_ctl_ff[`BIT_SQUELCH];
		// The receive clock is the complement of the transmit clock in sync mode
		tx_data_clock_pin <= sync_fsk && bit_tick;
		rx_data_clock_pin <= sync_fsk && !bit_tick;
		// Outside half duplex the carrier is not switched by RTS
		carrier_on        <= fsk1200_half_duplex ? (rts_s && dtr_s) : 1'b1;
		unscr_ff          <= u1_s && data_s;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts and read-back

// Status bits are sticky; a read returns and clears them in one step, and an
// event in the cycle of the read is kept for the next read
wire [3:0] irq_ev = {unscr_ff & ~(u1_s & data_s), pat_event, init_done_ev, ack_done_ev};
wire       rd_stat = reg_rd && (reg_addr == `OFS_IRQ_STATUS);

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		irq_stat_ff <= 4'h0;
		irq_mask_ff <= 4'h0;
		reg_rdata   <= `RST_BYTE;
	end else begin
		irq_stat_ff <= (rd_stat ? 4'h0 : irq_stat_ff) | irq_ev;   // Event beats read clear
		if (reg_wr && (reg_addr == `OFS_IRQ_MASK))
			irq_mask_ff <= reg_wdata[3:0];
		// Read data stands one cycle after the strobe and is zero otherwise
		reg_rdata <= `RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
			`OFS_DET_ENABLE:   reg_rdata <= det_enable_ff;
			`OFS_VOICE_RX:     reg_rdata <= voice_rx_ff;
			`OFS_VOICE_CTL:    reg_rdata <= voice_ctl_ff;
			`OFS_TX_MODE:      reg_rdata <= tx_mode_ff;
			`OFS_DETECT_STAT:  reg_rdata <= {4'h0, unscr_ff, 3'h0};
			`OFS_PATTERN_STAT: reg_rdata <= {7'h00, pat_det_ff};
			`OFS_VOICE_TX_BUF: reg_rdata <= vbuf_ff;
			`OFS_VOICE_TX:     reg_rdata <= voice_tx_ff;
			`OFS_SEC_TX_BUF:   reg_rdata <= secbuf_ff;
			`OFS_CONFIG:       reg_rdata <= config_ff;
			`OFS_IRQ_STATUS:   reg_rdata <= {4'h0, irq_stat_ff};
			`OFS_IRQ_MASK:     reg_rdata <= {4'h0, irq_mask_ff};
			default:           reg_rdata <= `RST_BYTE;
			endcase
		end
	end
end

// Level interrupt straight from the registers, so it drops the cycle after a read
assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule // voice_loop_ctrl

/* File: verilog/voice_loop_defs.vh */
// Offsets, bit positions, reset values and timing counts of the voice and loopback control bank
`ifndef VOICE_LOOP_DEFS_VH
`define VOICE_LOOP_DEFS_VH

// Interface memory offsets, word index on the 8-bit register port
`define OFS_DET_ENABLE    5'h02
`define OFS_VOICE_RX      5'h04
`define OFS_VOICE_CTL     5'h05
`define OFS_TX_MODE       5'h08
`define OFS_DETECT_STAT   5'h0D
`define OFS_PATTERN_STAT  5'h0F
`define OFS_VOICE_TX_BUF  5'h10
`define OFS_VOICE_TX      5'h11
`define OFS_SEC_TX_BUF    5'h12
`define OFS_CONFIG        5'h13
`define OFS_IRQ_STATUS    5'h1E
`define OFS_IRQ_MASK      5'h1F

// Bit positions
`define BIT_ACK_DET_EN    1
`define BIT_VOICE_AGC     2
`define BIT_SQUELCH       4
`define BIT_VOICE_INIT    5
`define BIT_ACK_SEND      3
`define BIT_SYNC_SEL      5
`define BIT_PAR_MODE      6
`define BIT_UNSCR_ONES    3
`define BIT_PAT_DET       0
`define BIT_HALF_DUPLEX   2
`define BIT_TX_VOICE      4
`define BIT_RX_VOICE      5
`define BIT_DEC_EN        6
`define BIT_FIFO_EN       7
`define BIT_NEW_CONFIGURATION_CODE      7

// Configuration codes
`define CONFIGURATION_CODE_DTMF_A       8'hAC
`define CONFIGURATION_CODE_TONE_0       8'h80
`define CONFIGURATION_CODE_TONE_1       8'h81
`define CONFIGURATION_CODE_TONE_3       8'h83
`define CONFIGURATION_CODE_TONE_6       8'h86
`define CONFIGURATION_CODE_FSK300       8'hA0
`define CONFIGURATION_CODE_FSK300_CH2   8'hA8
`define CONFIGURATION_CODE_FSK1200      8'hA4

// Interrupt status bits
`define IRQ_ACK_DONE      0
`define IRQ_VOICE_UP      1
`define IRQ_PAT_DET       2
`define IRQ_UNSCR_ONES    3

// Reset values
`define RST_BYTE          8'h00

// Timing
`define ACK_PATTERN_BITS  1948
`define CLK_MHZ           250
`define VOICE_RATE_HZ     7200
`define VOICE_DIV         ((`CLK_MHZ * 1000000) / `VOICE_RATE_HZ)
`define VOICE_INIT_NS     1000
`define VOICE_INIT_CYC    ((`VOICE_INIT_NS * `CLK_MHZ + 999) / 1000)

`endif
